// ### design/trs_owner.v
`timescale 1ns/10ps
module trs_owner (
  // Clock and reset
  input  wire clk_in,
  input  wire reset_n_in,
  input  wire ce_in,
  input  wire shutdown_in,
  // Request and arbitration
  input  wire request_in,
  input  wire mask_ok_in,
  input  wire other_owner_in,
  output reg  owned_out
);

  wire keep;
  wire gain;

  assign keep = request_in & mask_ok_in;
  assign gain = keep & ~other_owner_in;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      owned_out <= 1'b0;
    end else if (ce_in) begin
      if (shutdown_in) begin
        owned_out <= 1'b0;
      end else if (owned_out) begin
        owned_out <= keep;
      end else begin
        owned_out <= gain;
      end
    end
  end

endmodule // trs_owner

// ### design/trs_regs.vh
// Summary of operation
// - Three speed-select levels combine into one code picking one of 8 sources.
// - Code 000 picks choice A, 001 choice B, 010..111 presets 2..7.
// - Choices A and B carry a source code; presets 1..7 are legal targets.
// - A directly picked preset supplies its stored frequency as reference.
// - Speed selects act only with terminal bit set in reference and logic masks.
// - One reference owner at a time; foreign owner blocks gaining it but not keeping it.
// - Configured speed select requests reference ownership; granted if masks ok, free.
// - Reference ownership kept until shutdown, mask cleared, or no select configured.
// - Unconfigured speed-select functions read as open; full mapping still applies.
// - Each physical input gets its function from a per-input assignment field.
// - Closed auto/manual input selects the manual analog choice as reference.
// - Granted manual reference overrides selects, other commands, mask and owner.
// - Open auto/manual input withdraws request; no requests returns to automatic.
// - Manual requests from several devices are arbitrated; only one granted.
// - Accel rate chosen by terminal only with accel and logic mask bits set.
// - Decel rate chosen by terminal only with decel and logic mask bits set.
// - Separate scheme: open selects time 1, closed selects time 2, each ramp.
// - One rate owner at a time; terminal affects ramps only while owner.
// - Configured accel select requests accel ownership; granted if masks ok, free.
// - Accel ownership kept until shutdown, mask cleared, or function unconfigured.
// - Decel ownership follows the accel conditions using the decel mask.
// - Combined scheme: one input selects both time 1 or both time 2.
`ifndef TRS_REGS_VH
`define TRS_REGS_VH

`define TRS_NUM_DIN      6
`define TRS_FSEL_W       4
`define TRS_FSEL_BUS_W   24
`define TRS_MASK_W       8
`define TRS_TB_BIT       0
`define TRS_SRC_W        4
`define TRS_FREQ_W       16
`define TRS_PRESETS_W    112

// Input function assignment codes
`define TRS_FN_NONE      4'h0
`define TRS_FN_SPD1      4'h1
`define TRS_FN_SPD2      4'h2
`define TRS_FN_SPD3      4'h3
`define TRS_FN_AUTOMAN   4'h4
`define TRS_FN_ACC2      4'h5
`define TRS_FN_DEC2      4'h6
`define TRS_FN_ACCDEC2   4'h7

// Source codes: presets n are code n, others are external sources
`define TRS_SRC_PRESET1  4'h1
`define TRS_SRC_PRESET7  4'h7

// Speed select codes for the two indirect choices
`define TRS_CODE_REF_A   3'h0
`define TRS_CODE_REF_B   3'h1

// Reset values
`define TRS_RST_SRC      4'h0
`define TRS_RST_FREQ     16'h0000
`define TRS_RST_GRANT    8'h00

`endif

// ### design/trs_sync.v
`timescale 1ns/10ps
module trs_sync (
  // Clock and reset
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire       ce_in,
  // Pins
  input  wire [5:0] pins_in,
  output reg  [5:0] sync_out
);

  reg [5:0] stage1_reg;

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_reg <= 6'h00;
      sync_out   <= 6'h00;
    end else if (ce_in) begin
      stage1_reg <= pins_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule // trs_sync

// ### design/trs_top.v
`timescale 1ns/10ps
`include "trs_regs.vh"
module trs_top (
  // Clock, reset and enable
  input  wire                      clk_in,
  input  wire                      reset_n_in,
  input  wire                      ce_in,
  input  wire                      shutdown_in,
  // Physical terminal inputs, closed = 1
  input  wire [`TRS_NUM_DIN-1:0]   din_pins_in,
  // Per-input function assignment, 4 bits per input
  input  wire [`TRS_FSEL_BUS_W-1:0] din_func_sel_in,
  // Masks, one bit per control device
  input  wire [`TRS_MASK_W-1:0]    logic_mask_in,
  input  wire [`TRS_MASK_W-1:0]    ref_mask_in,
  input  wire [`TRS_MASK_W-1:0]    accel_mask_in,
  input  wire [`TRS_MASK_W-1:0]    decel_mask_in,
  // Ownership held by other devices
  input  wire                      ref_owner_other_in,
  input  wire                      accel_owner_other_in,
  input  wire                      decel_owner_other_in,
  // Manual requests of other devices, bit 0 unused
  input  wire [`TRS_MASK_W-1:0]    manual_req_other_in,
  // Reference parameters
  input  wire [`TRS_SRC_W-1:0]     ref_a_choice_in,
  input  wire [`TRS_SRC_W-1:0]     ref_b_choice_in,
  input  wire [`TRS_SRC_W-1:0]     manual_analog_choice_in,
  input  wire [`TRS_PRESETS_W-1:0] preset_freq_in,
  // Reference selection results
  output reg  [2:0]                speed_code_out,
  output reg  [`TRS_SRC_W-1:0]     ref_source_out,
  output reg  [`TRS_FREQ_W-1:0]    ref_freq_out,
  output reg                       ref_freq_valid_out,
  output reg                       ref_manual_out,
  output reg                       ref_tb_ctrl_out,
  output reg  [`TRS_MASK_W-1:0]    manual_grant_out,
  // Ownership
  output wire                      ref_owner_out,
  output wire                      accel_owner_out,
  output wire                      decel_owner_out,
  // Ramp selection, 0 = time 1, 1 = time 2
  output reg                       accel_time2_out,
  output reg                       decel_time2_out
);

  // True when any input is assigned the given function
  function has_func;
    input [`TRS_FSEL_BUS_W-1:0] sel;
    input [`TRS_FSEL_W-1:0]     code;
    integer i;
    begin
      has_func = 1'b0;
      for (i = 0; i < `TRS_NUM_DIN; i = i + 1) begin
        if (sel[i*`TRS_FSEL_W +: `TRS_FSEL_W] == code) begin
          has_func = 1'b1;
        end
      end
    end
  endfunction

  // Level of a function; an unassigned function reads open
  function func_level;
    input [`TRS_FSEL_BUS_W-1:0] sel;
    input [`TRS_FSEL_W-1:0]     code;
    input [`TRS_NUM_DIN-1:0]    pins;
    integer i;
    begin
      func_level = 1'b0;
      for (i = 0; i < `TRS_NUM_DIN; i = i + 1) begin
        if (sel[i*`TRS_FSEL_W +: `TRS_FSEL_W] == code) begin
          func_level = func_level | pins[i];
        end
      end
    end
  endfunction

  // Frequency of preset n, n = 1..7
  function [`TRS_FREQ_W-1:0] preset_pick;
    input [`TRS_PRESETS_W-1:0] presets;
    input [`TRS_SRC_W-1:0]     idx;
    integer n;
    begin
      preset_pick = `TRS_RST_FREQ;
      for (n = 1; n <= 7; n = n + 1) begin
        if (idx == n[`TRS_SRC_W-1:0]) begin
          preset_pick = presets[(n-1)*`TRS_FREQ_W +: `TRS_FREQ_W];
        end
      end
    end
  endfunction

  // True for source codes that name one of the stored presets
  function is_preset;
    input [`TRS_SRC_W-1:0] src;
    begin
      is_preset = (src >= `TRS_SRC_PRESET1) && (src <= `TRS_SRC_PRESET7);
    end
  endfunction

  // Terminal bit set in both the function mask and the logic mask
  function tb_allowed;
    input [`TRS_MASK_W-1:0] fmask;
    input [`TRS_MASK_W-1:0] lmask;
    begin
      tb_allowed = fmask[`TRS_TB_BIT] & lmask[`TRS_TB_BIT];
    end
  endfunction

  // Input synchroniser
  wire [`TRS_NUM_DIN-1:0] din_sync;

  trs_sync u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .pins_in    (din_pins_in),
    .sync_out   (din_sync)
  );

  // Function decode
  wire spd_cfg;
  wire accel_cfg;
  wire decel_cfg;
  wire accel_level;
  wire decel_level;
  wire tb_man_req;
  wire [2:0] spd_code;

  assign spd_cfg = has_func(din_func_sel_in, `TRS_FN_SPD1) |
                   has_func(din_func_sel_in, `TRS_FN_SPD2) |
                   has_func(din_func_sel_in, `TRS_FN_SPD3);

  // Unconfigured selects stay open, table still applies
  assign spd_code = {func_level(din_func_sel_in, `TRS_FN_SPD3, din_sync),
                     func_level(din_func_sel_in, `TRS_FN_SPD2, din_sync),
                     func_level(din_func_sel_in, `TRS_FN_SPD1, din_sync)};

  // Ramp ownership requests follow configuration, not pin levels
  assign accel_cfg = has_func(din_func_sel_in, `TRS_FN_ACC2) |
                     has_func(din_func_sel_in, `TRS_FN_ACCDEC2);
  assign decel_cfg = has_func(din_func_sel_in, `TRS_FN_DEC2) |
                     has_func(din_func_sel_in, `TRS_FN_ACCDEC2);

  assign accel_level =
    func_level(din_func_sel_in, `TRS_FN_ACC2, din_sync) |
    func_level(din_func_sel_in, `TRS_FN_ACCDEC2, din_sync);
  assign decel_level =
    func_level(din_func_sel_in, `TRS_FN_DEC2, din_sync) |
    func_level(din_func_sel_in, `TRS_FN_ACCDEC2, din_sync);

  // Open auto/manual input withdraws the terminal request
  assign tb_man_req =
    func_level(din_func_sel_in, `TRS_FN_AUTOMAN, din_sync);

  // Mask qualification
  wire ref_mask_ok;
  wire accel_mask_ok;
  wire decel_mask_ok;

  assign ref_mask_ok   = tb_allowed(ref_mask_in, logic_mask_in);
  assign accel_mask_ok = tb_allowed(accel_mask_in, logic_mask_in);
  assign decel_mask_ok = tb_allowed(decel_mask_in, logic_mask_in);

  // Ownership cells; the registered owner lags a request by one edge,
  // so the output paths also test the live mask to let go at once
  trs_owner u_ref_own (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .ce_in          (ce_in),
    .shutdown_in    (shutdown_in),
    .request_in     (spd_cfg),
    .mask_ok_in     (ref_mask_ok),
    .other_owner_in (ref_owner_other_in),
    .owned_out      (ref_owner_out)
  );

  trs_owner u_accel_own (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .ce_in          (ce_in),
    .shutdown_in    (shutdown_in),
    .request_in     (accel_cfg),
    .mask_ok_in     (accel_mask_ok),
    .other_owner_in (accel_owner_other_in),
    .owned_out      (accel_owner_out)
  );

  trs_owner u_decel_own (
    .clk_in         (clk_in),
    .reset_n_in     (reset_n_in),
    .ce_in          (ce_in),
    .shutdown_in    (shutdown_in),
    .request_in     (decel_cfg),
    .mask_ok_in     (decel_mask_ok),
    .other_owner_in (decel_owner_other_in),
    .owned_out      (decel_owner_out)
  );

  // Manual reference arbitration
  wire [`TRS_MASK_W-1:0] man_reqs;
  wire [`TRS_MASK_W-1:0] man_held;
  reg  [`TRS_MASK_W-1:0] man_grant_next;
  integer k;

  // Terminal request sits in bit 0, other devices above it
  assign man_reqs = {manual_req_other_in[`TRS_MASK_W-1:1], tb_man_req};
  assign man_held = manual_grant_out & man_reqs;

  // Holder keeps the grant; otherwise lowest requesting device wins
  always @* begin
    man_grant_next = `TRS_RST_GRANT;
    if (man_held != `TRS_RST_GRANT) begin
      man_grant_next = man_held;
    end else begin
      for (k = `TRS_MASK_W - 1; k >= 0; k = k - 1) begin
        if (man_reqs[k]) begin
          man_grant_next = `TRS_RST_GRANT;
          man_grant_next[k] = 1'b1;
        end
      end
    end
  end

  // Reference selection
  reg [`TRS_SRC_W-1:0]  auto_src;
  reg [`TRS_FREQ_W-1:0] auto_freq;
  reg                   auto_valid;

  always @* begin
    auto_src   = `TRS_RST_SRC;
    auto_freq  = `TRS_RST_FREQ;
    auto_valid = 1'b0;
    case (spd_code)
      `TRS_CODE_REF_A: begin
        auto_src = ref_a_choice_in;
      end
      `TRS_CODE_REF_B: begin
        auto_src = ref_b_choice_in;
      end
      default: begin
        auto_src = {1'b0, spd_code};
      end
    endcase
    // A source outside the presets carries no frequency here
    if (is_preset(auto_src)) begin
      auto_freq  = preset_pick(preset_freq_in, auto_src);
      auto_valid = 1'b1;
    end
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      speed_code_out     <= 3'h0;
      ref_source_out     <= `TRS_RST_SRC;
      ref_freq_out       <= `TRS_RST_FREQ;
      ref_freq_valid_out <= 1'b0;
      ref_manual_out     <= 1'b0;
      ref_tb_ctrl_out    <= 1'b0;
      manual_grant_out   <= `TRS_RST_GRANT;
    end else if (ce_in) begin
      speed_code_out   <= spd_code;
      manual_grant_out <= man_grant_next;
      if (man_grant_next[`TRS_TB_BIT]) begin
        // Terminal manual mode overrides every other selection path
        ref_source_out     <= manual_analog_choice_in;
        ref_freq_valid_out <= 1'b0;
        ref_manual_out     <= 1'b1;
        ref_tb_ctrl_out    <= 1'b1;
      end else if (man_grant_next != `TRS_RST_GRANT) begin
        // Another device in manual mode supplies its own reference
        ref_manual_out  <= 1'b1;
        ref_tb_ctrl_out <= 1'b0;
      end else if (ref_owner_out && ref_mask_ok) begin
        ref_source_out     <= auto_src;
        ref_freq_out       <= auto_freq;
        ref_freq_valid_out <= auto_valid;
        ref_manual_out     <= 1'b0;
        ref_tb_ctrl_out    <= 1'b1;
      end else begin
        // No ownership or mask clear: selects have no effect, last choice held
        ref_manual_out  <= 1'b0;
        ref_tb_ctrl_out <= 1'b0;
      end
    end
  end

  // Ramp rate selection
  // Without ownership the last chosen rate stays in force
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      accel_time2_out <= 1'b0;
      decel_time2_out <= 1'b0;
    end else if (ce_in) begin
      if (accel_owner_out && accel_mask_ok) begin
        accel_time2_out <= accel_level;
      end
      if (decel_owner_out && decel_mask_ok) begin
        decel_time2_out <= decel_level;
      end
    end
  end

endmodule // trs_top

// ### test/trs_contacts.sv
`timescale 1ns/10ps
module trs_contacts (
  // Commanded contact states, 1 = closed
  input  wire logic [5:0] close_in,
  // Drive terminal inputs
  output wire logic [5:0] pins_out
);
  // A dry contact only closes or opens; an open one reads as 0
  assign pins_out = close_in;
endmodule // trs_contacts

// ### test/trs_top_asserts.sv
`timescale 1ns/10ps
`include "trs_regs.vh"
module trs_top_asserts (
  // Clock and control
  input wire                   clk_in,
  input wire                   reset_n_in,
  input wire                   ce_in,
  input wire                   shutdown_in,
  // Masks and foreign owners
  input wire [`TRS_MASK_W-1:0] logic_mask_in,
  input wire [`TRS_MASK_W-1:0] ref_mask_in,
  input wire [`TRS_MASK_W-1:0] accel_mask_in,
  input wire                   ref_owner_other_in,
  input wire                   decel_owner_other_in,
  // Observed outputs
  input wire [`TRS_MASK_W-1:0] manual_grant_out,
  input wire                   ref_manual_out,
  input wire                   ref_owner_out,
  input wire                   accel_owner_out,
  input wire                   decel_owner_out,
  input wire                   accel_time2_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_grant_onehot: assert property ($onehot0(manual_grant_out))
    else $error("manual grant not one-hot");
  chk_manual_flag: assert property (
    ref_manual_out == (|manual_grant_out))
    else $error("manual flag differs from grants");
  chk_ref_refused: assert property (
    !ref_owner_out && ref_owner_other_in |=> !ref_owner_out)
    else $error("reference taken from another owner");
  chk_ref_release: assert property (
    ce_in && !(ref_mask_in[0] && logic_mask_in[0]) |=> !ref_owner_out)
    else $error("reference kept with mask clear");
  chk_shutdown_drop: assert property (
    ce_in && shutdown_in |=>
      !ref_owner_out && !accel_owner_out && !decel_owner_out)
    else $error("ownership kept at shutdown");
  chk_accel_release: assert property (
    ce_in && !(accel_mask_in[0] && logic_mask_in[0]) |=> !accel_owner_out)
    else $error("accel kept with mask clear");
  chk_decel_refused: assert property (
    !decel_owner_out && decel_owner_other_in |=> !decel_owner_out)
    else $error("decel taken from another owner");
  chk_ramp_hold: assert property (
    !accel_owner_out |=> $stable(accel_time2_out))
    else $error("accel rate changed without ownership");
endmodule // trs_top_asserts

bind trs_top trs_top_asserts chk_u (.clk_in, .reset_n_in, .ce_in,
  .shutdown_in, .logic_mask_in, .ref_mask_in, .accel_mask_in,
  .ref_owner_other_in, .decel_owner_other_in, .manual_grant_out,
  .ref_manual_out, .ref_owner_out, .accel_owner_out, .decel_owner_out,
  .accel_time2_out);

// ### test/trs_top_tb.sv
`timescale 1ns/10ps
`include "trs_regs.vh"
module trs_top_tb;
  logic         clk_in = 1'b0, reset_n_in = 1'b0;
  logic         ce_in = 1'b1, shutdown_in = 1'b0;
  logic [5:0]   contacts = 6'h00;
  logic [23:0]  din_func_sel_in = 24'h465321;
  logic [7:0]   logic_mask_in = 8'hff, ref_mask_in = 8'hff;
  logic [7:0]   accel_mask_in = 8'hff, decel_mask_in = 8'hff;
  logic         ref_owner_other_in = 1'b0, accel_owner_other_in = 1'b0;
  logic         decel_owner_other_in = 1'b0;
  logic [7:0]   manual_req_other_in = 8'h00;
  logic [3:0]   ref_a_choice_in = 4'h3, ref_b_choice_in = 4'h9;
  logic [3:0]   manual_analog_choice_in = 4'ha;
  logic [111:0] preset_freq_in = 112'h0;
  wire  [5:0]   din_pins_in;
  wire  [2:0]   speed_code_out;
  wire  [3:0]   ref_source_out;
  wire  [15:0]  ref_freq_out;
  wire  [7:0]   manual_grant_out;
  wire          ref_freq_valid_out, ref_manual_out, ref_tb_ctrl_out;
  wire          ref_owner_out, accel_owner_out, decel_owner_out;
  wire          accel_time2_out, decel_time2_out;
  wire  [2:0]   owners = {ref_owner_out, accel_owner_out, decel_owner_out};
  wire  [1:0]   rates = {accel_time2_out, decel_time2_out};
  int           n_mismatch = 0, n_checks = 0;

  always #50 clk_in = ~clk_in;

  trs_contacts contacts_u (.close_in(contacts), .pins_out(din_pins_in));
  trs_top dut_u (.clk_in, .reset_n_in, .ce_in, .shutdown_in, .din_pins_in,
    .din_func_sel_in, .logic_mask_in, .ref_mask_in, .accel_mask_in,
    .decel_mask_in, .ref_owner_other_in, .accel_owner_other_in,
    .decel_owner_other_in, .manual_req_other_in, .ref_a_choice_in,
    .ref_b_choice_in, .manual_analog_choice_in, .preset_freq_in,
    .speed_code_out, .ref_source_out, .ref_freq_out, .ref_freq_valid_out,
    .ref_manual_out, .ref_tb_ctrl_out, .manual_grant_out, .ref_owner_out,
    .accel_owner_out, .decel_owner_out, .accel_time2_out, .decel_time2_out);

  task check(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs change 1 ns after the edge
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task check_ref(input logic [3:0] src);
    check("ref_source", ref_source_out, src);
    check("ref_valid", ref_freq_valid_out, src >= 1 && src <= 7);
    if (src >= 1 && src <= 7)
      check("ref_freq", ref_freq_out, 16'h1100 * src);
  endtask

  task t_power_up;
    check("owners in reset", owners, 3'h0);
    reset_n_in = 1'b1;
    tick(3);
    check("owners", owners, 3'h7);
    check("tb ctrl", ref_tb_ctrl_out, 1'b1);
    check_ref(4'h3);
  endtask

  task t_codes;
    for (int c = 0; c < 8; c++) begin
      contacts[2:0] = c[2:0];
      tick(4);
      check("speed_code", speed_code_out, c[2:0]);
      check_ref(c == 0 ? 4'h3 : c == 1 ? 4'h9 : c[3:0]);
    end
  endtask

  task t_sync;
    contacts[2:0] = 3'h2;
    tick(2);
    check("code before sync", speed_code_out, 3'h7);
    tick(1);
    check("code after sync", speed_code_out, 3'h2);
    ce_in = 1'b0;
    contacts[2:0] = 3'h5;
    tick(5);
    check("frozen code", speed_code_out, 3'h2);
    ce_in = 1'b1;
  endtask

  task t_remap;
    din_func_sel_in[11:0] = 12'h032;
    contacts[2:0] = 3'h7;
    tick(4);
    check("remap code", speed_code_out, 3'h6);
    check_ref(4'h6);
    din_func_sel_in[11:0] = 12'h000;
    tick(3);
    check("ref owner unconf", ref_owner_out, 1'b0);
    din_func_sel_in[11:0] = 12'h321;
    tick(3);
    check("ref owner reconf", ref_owner_out, 1'b1);
  endtask

  task t_owner;
    ref_mask_in[0] = 1'b0;
    tick(3);
    check("ref owner masked", ref_owner_out, 1'b0);
    check("tb ctrl masked", ref_tb_ctrl_out, 1'b0);
    contacts[2:0] = 3'h0;
    tick(4);
    check("held source", ref_source_out, 4'h7);
    ref_owner_other_in = 1'b1;
    ref_mask_in[0] = 1'b1;
    tick(3);
    check("ref refused", ref_owner_out, 1'b0);
    check("ignored source", ref_source_out, 4'h7);
    ref_owner_other_in = 1'b0;
    tick(3);
    check("ref granted", ref_owner_out, 1'b1);
    ref_owner_other_in = 1'b1;
    tick(2);
    check("ref kept", ref_owner_out, 1'b1);
    ref_owner_other_in = 1'b0;
    logic_mask_in[0] = 1'b0;
    tick(2);
    check("logic masked", owners, 3'h0);
    logic_mask_in[0] = 1'b1;
    shutdown_in = 1'b1;
    tick(2);
    check("shutdown", owners, 3'h0);
    shutdown_in = 1'b0;
    tick(3);
    check("regained", owners, 3'h7);
  endtask

  task t_manual;
    ref_mask_in[0] = 1'b0;
    contacts[5] = 1'b1;
    tick(4);
    check("tb manual grant", manual_grant_out, 8'h01);
    check("manual flag", ref_manual_out, 1'b1);
    check("tb manual ctrl", ref_tb_ctrl_out, 1'b1);
    check_ref(4'ha);
    manual_req_other_in = 8'h28;
    tick(2);
    check("holder keeps", manual_grant_out, 8'h01);
    contacts[5] = 1'b0;
    tick(4);
    check("next holder", manual_grant_out, 8'h08);
    check("foreign manual", ref_tb_ctrl_out, 1'b0);
    manual_req_other_in = 8'h00;
    tick(2);
    check("automatic", ref_manual_out, 1'b0);
    ref_mask_in[0] = 1'b1;
    tick(3);
  endtask

  task t_ramp;
    contacts[4:3] = 2'b01;
    tick(4);
    check("accel only", rates, 2'b10);
    contacts[4] = 1'b1;
    tick(4);
    check("both two", rates, 2'b11);
    accel_mask_in[0] = 1'b0;
    decel_mask_in[0] = 1'b0;
    contacts[4:3] = 2'b00;
    tick(4);
    check("accel unowned", accel_owner_out, 1'b0);
    check("decel unowned", decel_owner_out, 1'b0);
    check("rates held", rates, 2'b11);
    {accel_owner_other_in, decel_owner_other_in} = 2'b11;
    {accel_mask_in[0], decel_mask_in[0]} = 2'b11;
    tick(3);
    check("ramp refused", owners[1:0], 2'b00);
    check("refused rates held", rates, 2'b11);
    {accel_owner_other_in, decel_owner_other_in} = 2'b00;
    tick(4);
    check("ramp owners", owners[1:0], 2'b11);
    check("ramp regained", rates, 2'b00);
    din_func_sel_in[23:12] = 12'h700;
    contacts[5] = 1'b1;
    tick(4);
    check("combined two", rates, 2'b11);
    contacts[5] = 1'b0;
    tick(4);
    check("combined one", rates, 2'b00);
  endtask

  // Reset in mid-run with every ownership held and time 2 selected
  task t_reset;
    contacts[5] = 1'b1;
    tick(4);
    check("rates before reset", rates, 2'b11);
    reset_n_in = 1'b0;
    tick(1);
    check("owners at reset", owners, 3'h0);
    check("rates at reset", rates, 2'b00);
    check("grant at reset", manual_grant_out, 8'h00);
    reset_n_in = 1'b1;
    tick(1);
    check("owners first edge", owners, 3'h7);
    tick(3);
    check("rates after reset", rates, 2'b11);
    check_ref(4'h3);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    summarize;
  end

  initial begin
    for (int n = 1; n <= 7; n++)
      preset_freq_in[16*n-16 +: 16] = 16'h1100 * n;
    tick(6);
    t_power_up;
    t_codes;
    t_sync;
    t_remap;
    t_owner;
    t_manual;
    t_ramp;
    t_reset;
    summarize;
  end
endmodule // trs_top_tb
